// ==== active_table.sv ====
`timescale 1ns/100ps
module active_table
   import eoi_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Acknowledge from priority logic
   input wire logic ack_valid,
   input wire logic [ID_W-1:0] ack_id,
   input wire logic [PRIO_W-1:0] ack_prio,
   // Operations
   input wire logic drop_valid,
   input wire logic [ID_W-1:0] drop_id,
   input wire logic deact_valid,
   input wire logic [ID_W-1:0] deact_id,
   // State
   output logic [PRIO_W-1:0] running_prio,
   output logic [ACT_DEPTH-1:0] active_mask,
   output logic [ACT_DEPTH-1:0] dropped_mask
);
   logic [ID_W-1:0] id_mem [ACT_DEPTH];
   logic [PRIO_W-1:0] prio_mem [ACT_DEPTH];
   logic [ACT_DEPTH-1:0] valid_reg;
   logic [ACT_DEPTH-1:0] prio_set_reg;
   logic [$clog2(ACT_DEPTH)-1:0] free_slot;

   // ---------------------------------------------------------------
   // Free slot and running priority
   // ---------------------------------------------------------------
   always_comb begin
      free_slot = '0;
      for (int i = ACT_DEPTH - 1; i >= 0; i--) begin
         if (!valid_reg[i]) begin
            free_slot = i[$clog2(ACT_DEPTH)-1:0];
         end
      end
   end

   always_comb begin
      running_prio = IDLE_PRIO;
      for (int i = 0; i < ACT_DEPTH; i++) begin
         if (valid_reg[i] && prio_set_reg[i] && prio_mem[i] < running_prio) begin
            running_prio = prio_mem[i];
         end
      end
   end

   // ---------------------------------------------------------------
   // Active and priority state, kept apart
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         valid_reg <= '0;
         prio_set_reg <= '0;
      end else begin
         for (int i = 0; i < ACT_DEPTH; i++) begin
            if (valid_reg[i] && drop_valid && id_mem[i] == drop_id) begin
               prio_set_reg[i] <= 1'b0;
            end
            if (valid_reg[i] && deact_valid && id_mem[i] == deact_id) begin
               valid_reg[i] <= prio_set_reg[i] && !(drop_valid && id_mem[i] == drop_id);
               // Active priority survives a deactivate without prior drop
               if (!prio_set_reg[i] || (drop_valid && id_mem[i] == drop_id)) begin
                  valid_reg[i] <= 1'b0;
               end
            end
         end
         if (ack_valid && !(&valid_reg)) begin
            valid_reg[free_slot] <= 1'b1;
            prio_set_reg[free_slot] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (ack_valid && !(&valid_reg)) begin
         id_mem[free_slot] <= ack_id;
         prio_mem[free_slot] <= ack_prio;
      end
   end

   always_comb begin
      for (int i = 0; i < ACT_DEPTH; i++) begin
         active_mask[i] = valid_reg[i];
         dropped_mask[i] = valid_reg[i] && !prio_set_reg[i];
      end
   end
endmodule : active_table

// ==== core_model.sv ====
`timescale 1ns/100ps
module core_model
   import eoi_pkg::*;
(
   // Clock
   input wire logic clk,
   // Access request
   output logic sys_valid,
   output logic sys_write,
   output sysenc_s sys_enc,
   output logic [63:0] sys_wdata,
   output ctx_s sys_ctx,
   // Answer
   input wire logic [63:0] sys_rdata,
   input wire resp_s sys_resp,
   input wire logic sys_done,
   // Acknowledge feed
   output logic ack_valid,
   output logic [ID_W-1:0] ack_id,
   output logic [PRIO_W-1:0] ack_prio
);
   resp_s resp_got;
   logic [63:0] rdata_got;
   logic done_got;
   initial begin
      sys_valid = 1'b0;
      sys_write = 1'b0;
      sys_enc = '0;
      sys_wdata = '0;
      sys_ctx = {EL3, 8'h40};
      ack_valid = 1'b0;
      ack_id = '0;
      ack_prio = '0;
   end
   // ---------------------------------------------------------------
   // Requests, released lines show inverted values
   // ---------------------------------------------------------------
   task automatic access(input logic wr, input sysenc_s enc, input logic [63:0] wd);
      int n;
      @(posedge clk);
      #1;
      sys_valid = 1'b1;
      sys_write = wr;
      sys_enc = enc;
      sys_wdata = wd;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         sys_valid = 1'b0;
         n++;
      end while (sys_done !== 1'b1 && n < 4);
      done_got = sys_done;
      resp_got = sys_resp;
      rdata_got = sys_rdata;
      sys_enc = ~enc;
      sys_wdata = ~wd;
   endtask : access
   task automatic ack(input logic [ID_W-1:0] id, input logic [PRIO_W-1:0] prio);
      @(posedge clk);
      #1;
      ack_valid = 1'b1;
      ack_id = id;
      ack_prio = prio;
      @(posedge clk);
      #1;
      ack_valid = 1'b0;
      ack_id = ~id;
      ack_prio = ~prio;
   endtask : ack
endmodule : core_model

// ==== eoi_checker_sva.sv ====
`timescale 1ns/100ps
module eoi_checker
   import eoi_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Access
   input wire logic sys_valid,
   input wire logic sys_write,
   input wire sysenc_s sys_enc,
   input wire logic [63:0] sys_wdata,
   input wire ctx_s sys_ctx,
   input wire resp_s sys_resp,
   // Effects
   input wire logic [1:0] lower_level_control_ns,
   input wire logic [1:0] lower_level_control_s,
   input wire logic deact_valid,
   input wire logic [ID_W-1:0] deact_id,
   input wire logic drop_valid,
   input wire logic [ID_W-1:0] drop_id,
   input wire logic system_error_interrupt,
   input wire logic bp_nonsecure_g1_uses_g0,
   input wire logic bp_secure_g1_uses_g0
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ---------------------------------------------------------------
   // Decode of the request
   // ---------------------------------------------------------------
   logic top_cm_reg;
   wire logic [ID_W-1:0] id_in = sys_wdata[ID_W-1:0];
   wire logic [4:0] wl = sys_wdata[4:0];
   wire logic [5:0] want = {wl[4], wl[1], wl[3], wl[0], wl[1], wl[0]};
   wire logic [5:0] view = {lower_level_control_ns, lower_level_control_s,
      bp_nonsecure_g1_uses_g0, bp_secure_g1_uses_g0};
   wire logic is_ctl = sys_enc == {OP0_SYS, OP1_TOP, CRN_IC, CRM_CTL, OP2_CTL};
   wire logic is_dir = sys_enc == {OP0_SYS, OP1_LOW, CRN_IC, CRM_DEACT, OP2_DEACT};
   wire logic is_eoi = sys_enc == {OP0_SYS, OP1_LOW, CRN_IC, CRM_EOI0, OP2_EOI0};
   wire logic at_top = sys_ctx.level == EL3;
   wire logic eff = sys_valid && sys_write
      && (at_top ? sys_ctx.sysreg_top : sys_ctx.level == EL2);
   wire logic mode = at_top ? top_cm_reg :
      sys_ctx.nonsecure ? lower_level_control_ns[1] : lower_level_control_s[1];
   wire logic special = id_in >= SPECIAL_LO && id_in <= SPECIAL_HI;
   wire logic el1_dir = sys_valid && sys_write && is_dir && sys_ctx.level == EL1;
   always_ff @(posedge clk) begin
      if (eff && is_ctl && at_top) begin
         top_cm_reg <= sys_wdata[CM_TOP_BIT];
      end
   end
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   a_ctl_low_undef: assert property (sys_valid && is_ctl && !at_top
      |=> sys_resp.result == RES_UNDEF) else $error("control access below top level");
   a_top_enable_trap: assert property (sys_valid && at_top && !sys_ctx.sysreg_top
      && (is_ctl || is_dir || is_eoi) |=> sys_resp == {RES_TRAP, EL3, TRAP_CLASS})
      else $error("missing top level trap");
   a_low_enable_trap: assert property (el1_dir && !sys_ctx.sysreg_low
      |=> sys_resp == {RES_TRAP, EL1, TRAP_CLASS}) else $error("missing lower trap");
   a_hyp_trap: assert property (el1_dir && sys_ctx.sysreg_low && sys_ctx.el2_enabled
      && (sys_ctx.trap_deactivate || sys_ctx.trap_common_access)
      |=> sys_resp == {RES_TRAP, EL2, TRAP_CLASS} && !deact_valid)
      else $error("missing hypervisor trap");
   a_eoi_both: assert property (eff && is_eoi && !mode && !special
      |=> drop_valid && deact_valid && drop_id == $past(id_in) && deact_id == $past(id_in))
      else $error("mode 0 end write not drop and deactivate");
   a_eoi_drop_only: assert property (eff && is_eoi && mode && !special
      |=> drop_valid && !deact_valid && drop_id == $past(id_in))
      else $error("mode 1 end write not drop only");
   a_dir_deact: assert property (eff && is_dir && mode
      |=> deact_valid && !drop_valid && deact_id == $past(id_in))
      else $error("mode 1 deactivate write lost");
   a_dir_ignored: assert property (eff && is_dir && !mode
      |=> !deact_valid && !drop_valid && system_error_interrupt)
      else $error("mode 0 deactivate write not ignored");
   a_special_quiet: assert property (eff && is_eoi && special
      |=> !drop_valid && !deact_valid) else $error("special identifier acted on");
   a_ctl_alias: assert property (eff && is_ctl && at_top
      |=> view == $past(want)) else $error("bank view differs from control fields");
   c_eoi_mode1: cover property (eff && is_eoi && mode);
   c_dir_mode0: cover property (eff && is_dir && !mode);
   c_hyp_trap: cover property (el1_dir && sys_ctx.el2_enabled && sys_ctx.trap_deactivate);
endmodule : eoi_checker

bind eoi_deactivation_control eoi_checker eoi_checker_inst (
   .clk, .rst_n, .sys_valid, .sys_write, .sys_enc, .sys_wdata, .sys_ctx, .sys_resp,
   .lower_level_control_ns, .lower_level_control_s, .deact_valid, .deact_id, .drop_valid,
   .drop_id, .system_error_interrupt, .bp_nonsecure_g1_uses_g0, .bp_secure_g1_uses_g0
);

// ==== eoi_deactivation_control.sv ====
`timescale 1ns/100ps
module eoi_deactivation_control
   import eoi_pkg::*;
#(
   parameter bit HAVE_EL3 = 1'b1,
   parameter bit ID_24BIT = 1'b1,
   parameter bit SYSERR_SUPPORT = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // System register access from the core
   input wire logic sys_valid,
   input wire logic sys_write,
   input wire sysenc_s sys_enc,
   input wire logic [63:0] sys_wdata,
   input wire ctx_s sys_ctx,
   output logic [63:0] sys_rdata,
   output resp_s sys_resp,
   output logic sys_done,
   // Lower-level control view, per bank
   output logic [1:0] lower_level_control_ns,
   output logic [1:0] lower_level_control_s,
   // Acknowledge feed from priority logic
   input wire logic ack_valid,
   input wire logic [ID_W-1:0] ack_id,
   input wire logic [PRIO_W-1:0] ack_prio,
   // Toward the distributor
   output logic deact_valid,
   output logic [ID_W-1:0] deact_id,
   output logic drop_valid,
   output logic [ID_W-1:0] drop_id,
   output logic system_error_interrupt,
   // Binary point selection
   output logic bp_nonsecure_g1_uses_g0,
   output logic bp_secure_g1_uses_g0,
   // Running state
   output logic [PRIO_W-1:0] running_prio,
   output logic [ACT_DEPTH-1:0] active_mask
);
   logic cm_ns_reg;
   logic cm_s_reg;
   logic cm_top_reg;
   logic sbp_ns_reg;
   logic sbp_s_reg;
   logic hit_ctl;
   logic hit_deact;
   logic hit_eoi0;
   logic completion_mode;
   logic [ID_W-1:0] wr_id;
   logic id_special;
   resp_s resp;
   logic do_ok;
   logic drop_now;
   logic deact_now;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   function automatic logic enc_hit(sysenc_s e, logic [2:0] op1, logic [3:0] crm,
                                    logic [2:0] op2);
      enc_hit = e.op0 == OP0_SYS && e.op1 == op1 && e.crn == CRN_IC && e.crm == crm
                && e.op2 == op2;
   endfunction : enc_hit

   function automatic resp_s make_resp(result_e r, level_e t);
      return '{result: r, target: t, syndrome: (r == RES_TRAP) ? TRAP_CLASS : 6'h00};
   endfunction : make_resp

   assign hit_ctl = enc_hit(sys_enc, OP1_TOP, CRM_CTL, OP2_CTL);
   assign hit_deact = enc_hit(sys_enc, OP1_LOW, CRM_DEACT, OP2_DEACT);
   assign hit_eoi0 = enc_hit(sys_enc, OP1_LOW, CRM_EOI0, OP2_EOI0);

   // ---------------------------------------------------------------
   // Identifier width
   // ---------------------------------------------------------------
   always_comb begin
      wr_id = sys_wdata[ID_W-1:0];
      if (!ID_24BIT) begin
         wr_id[ID_W-1:ID_W16] = '0;
      end
   end

   assign id_special = wr_id >= SPECIAL_LO && wr_id <= SPECIAL_HI;

   // ---------------------------------------------------------------
   // Applicable completion mode
   // ---------------------------------------------------------------
   always_comb begin
      if (!HAVE_EL3) begin
         completion_mode = cm_ns_reg;
      end else if (sys_ctx.level == EL3) begin
         completion_mode = cm_top_reg;
      end else if (sys_ctx.nonsecure) begin
         completion_mode = cm_ns_reg;
      end else begin
         completion_mode = cm_s_reg;
      end
   end

   // ---------------------------------------------------------------
   // Access checks
   // ---------------------------------------------------------------
   always_comb begin
      resp = make_resp(RES_NONE, EL0);
      if (hit_ctl) begin
         if (!HAVE_EL3 || sys_ctx.level != EL3) begin
            resp = make_resp(RES_UNDEF, sys_ctx.level);
         end else if (!sys_ctx.sysreg_top) begin
            resp = make_resp(RES_TRAP, EL3);
         end else begin
            resp = make_resp(RES_OK, EL3);
         end
      end else if ((hit_deact || hit_eoi0) && !sys_write
                   && !(sys_ctx.level == EL3 && !sys_ctx.sysreg_top)) begin
         resp = make_resp(RES_UNDEF, sys_ctx.level);
      end else if (hit_deact || hit_eoi0) begin
         case (sys_ctx.level)
            EL0: begin
               resp = make_resp(RES_UNDEF, EL0);
            end
            EL1: begin
               if (!sys_ctx.sysreg_low) begin
                  resp = make_resp(RES_TRAP, EL1);
               end else if (hit_deact && sys_ctx.el2_enabled
                            && (sys_ctx.trap_deactivate || sys_ctx.trap_common_access)) begin
                  resp = make_resp(RES_TRAP, EL2);
               end else if (hit_deact && sys_ctx.el2_enabled
                            && (sys_ctx.route_fiq_to_hypervisor
                                || sys_ctx.route_irq_to_hypervisor)) begin
                  resp = make_resp(RES_VIRT, EL1);
               end else begin
                  resp = make_resp(RES_OK, EL1);
               end
            end
            EL3: begin
               if (!sys_ctx.sysreg_top) begin
                  resp = make_resp(RES_TRAP, EL3);
               end else begin
                  resp = make_resp(RES_OK, EL3);
               end
            end
            default: begin
               resp = make_resp(RES_OK, sys_ctx.level);
            end
         endcase
      end
   end

   assign do_ok = sys_valid && sys_write && resp.result == RES_OK;
   assign drop_now = do_ok && hit_eoi0 && !id_special;
   assign deact_now = (drop_now && !completion_mode)
                      || (do_ok && hit_deact && completion_mode);

   // ---------------------------------------------------------------
   // Top-level control fields, no reset value
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (do_ok && hit_ctl) begin
         cm_ns_reg <= sys_wdata[CM_NS_BIT];
         cm_s_reg <= sys_wdata[CM_S_BIT];
         cm_top_reg <= sys_wdata[CM_TOP_BIT];
         sbp_ns_reg <= sys_wdata[SBP_NS_BIT];
         sbp_s_reg <= sys_wdata[SBP_S_BIT];
      end
   end

   // Banked lower-level view shares the same flops
   always_comb begin
      lower_level_control_ns = '0;
      lower_level_control_s = '0;
      lower_level_control_ns[CTL_LOW_CM_BIT] = cm_ns_reg;
      lower_level_control_ns[CTL_LOW_SBP_BIT] = sbp_ns_reg;
      lower_level_control_s[CTL_LOW_CM_BIT] = cm_s_reg;
      lower_level_control_s[CTL_LOW_SBP_BIT] = sbp_s_reg;
   end

   assign bp_nonsecure_g1_uses_g0 = sbp_ns_reg;
   assign bp_secure_g1_uses_g0 = sbp_s_reg;

   // ---------------------------------------------------------------
   // Response and read data
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sys_done <= 1'b0;
         sys_resp <= make_resp(RES_NONE, EL0);
         sys_rdata <= '0;
      end else begin
         sys_done <= sys_valid;
         sys_resp <= resp;
         sys_rdata <= '0;
         if (sys_valid && !sys_write && hit_ctl && resp.result == RES_OK) begin
            sys_rdata[CM_NS_BIT] <= cm_ns_reg;
            sys_rdata[CM_S_BIT] <= cm_s_reg;
            sys_rdata[CM_TOP_BIT] <= cm_top_reg;
            sys_rdata[SBP_NS_BIT] <= sbp_ns_reg;
            sys_rdata[SBP_S_BIT] <= sbp_s_reg;
         end
      end
   end

   // ---------------------------------------------------------------
   // Distributor requests
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         drop_valid <= 1'b0;
         drop_id <= '0;
         deact_valid <= 1'b0;
         deact_id <= '0;
         system_error_interrupt <= 1'b0;
      end else begin
         drop_valid <= drop_now;
         deact_valid <= deact_now;
         system_error_interrupt <= SYSERR_SUPPORT && do_ok && hit_deact
                                   && !completion_mode;
         if (drop_now) begin
            drop_id <= wr_id;
         end
         if (deact_now) begin
            deact_id <= wr_id;
         end
      end
   end

   // ---------------------------------------------------------------
   // Active and priority tracking
   // ---------------------------------------------------------------
   active_table u_active_table (
      .clk(clk),
      .rst_n(rst_n),
      .ack_valid(ack_valid),
      .ack_id(ack_id),
      .ack_prio(ack_prio),
      .drop_valid(drop_now),
      .drop_id(wr_id),
      .deact_valid(deact_now),
      .deact_id(wr_id),
      .running_prio(running_prio),
      .active_mask(active_mask),
      .dropped_mask()
   );
endmodule : eoi_deactivation_control

// ==== eoi_pkg.sv ====
// Operation
// - Completion mode bits at 4 (non-secure EL1/EL2), 3 (secure EL1), 2 (EL3).
// - Completion mode 0: end write drops priority and deactivates the interrupt.
// - Completion mode 1: end write drops priority only; deactivate register deactivates.
// - Deactivate writes are ignored while completion mode is 0.
// - Optionally raise a system error on a deactivate write in mode 0.
// - Deactivate without prior end write deactivates; active priority stays set. Here the entry also stays set in active_mask.
// - Mode bit chosen by EL3 presence, current level and security state.
// - Bit 1: non-secure group 1 uses group 0 binary point when set.
// - Bit 0: secure group 1 uses group 0 binary point when set.
// - Lower-level control bank fields share storage with top-level control fields.
// - Completion mode and shared binary point fields have no defined reset value.
// - Top-level control at op0 3, op1 6, CRn 12, CRm 12, op2 4; undefined below EL3.
// - At EL3, accesses trap to EL3 with class 0x18 when sysreg enable is 0.
// - At EL1, deactivate write traps to EL1 when lower sysreg enable is 0.
// - At EL1 with EL2, trap bits go to EL2; routing bits go virtual.
// - Deactivate register write-only, identifier bits 23:0, op1 0, CRm 11, op2 1.
// - Identifier is 16 or 24 bits; unimplemented upper bits reserved zero.
// - Group 0 end register at op1 0, CRn 12, CRm 8, op2 1.
package eoi_pkg;
   // ---------------------------------------------------------------
   // Encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] OP0_SYS = 2'h3;
   localparam logic [2:0] OP1_TOP = 3'h6;
   localparam logic [2:0] OP1_LOW = 3'h0;
   localparam logic [3:0] CRN_IC = 4'hc;
   localparam logic [3:0] CRM_CTL = 4'hc;
   localparam logic [2:0] OP2_CTL = 3'h4;
   localparam logic [3:0] CRM_DEACT = 4'hb;
   localparam logic [2:0] OP2_DEACT = 3'h1;
   localparam logic [3:0] CRM_EOI0 = 4'h8;
   localparam logic [2:0] OP2_EOI0 = 3'h1;
   localparam logic [5:0] TRAP_CLASS = 6'h18;
   // ---------------------------------------------------------------
   // Control fields
   // ---------------------------------------------------------------
   localparam int CM_NS_BIT = 4;
   localparam int CM_S_BIT = 3;
   localparam int CM_TOP_BIT = 2;
   localparam int SBP_NS_BIT = 1;
   localparam int SBP_S_BIT = 0;
   localparam int CTL_LOW_CM_BIT = 1;
   localparam int CTL_LOW_SBP_BIT = 0;
   localparam int ID_W = 24;
   localparam int ID_W16 = 16;
   localparam logic [23:0] SPECIAL_LO = 24'h0003fc;
   localparam logic [23:0] SPECIAL_HI = 24'h0003ff;
   localparam int ACT_DEPTH = 8;
   localparam int PRIO_W = 8;
   localparam logic [PRIO_W-1:0] IDLE_PRIO = 8'hff;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      EL0 = 4'h1,
      EL1 = 4'h2,
      EL2 = 4'h4,
      EL3 = 4'h8
   } level_e;
   typedef struct packed {
      logic [1:0] op0;
      logic [2:0] op1;
      logic [3:0] crn;
      logic [3:0] crm;
      logic [2:0] op2;
   } sysenc_s;
   typedef struct packed {
      level_e level;
      logic nonsecure;
      logic sysreg_top;
      logic sysreg_low;
      logic el2_enabled;
      logic trap_deactivate;
      logic trap_common_access;
      logic route_fiq_to_hypervisor;
      logic route_irq_to_hypervisor;
   } ctx_s;
   typedef enum logic [4:0] {
      RES_OK = 5'h01,
      RES_UNDEF = 5'h02,
      RES_TRAP = 5'h04,
      RES_VIRT = 5'h08,
      RES_NONE = 5'h10
   } result_e;
   typedef struct packed {
      result_e result;
      level_e target;
      logic [5:0] syndrome;
   } resp_s;
endpackage : eoi_pkg

// ==== testbench.sv ====
`timescale 1ns/100ps
module testbench
   import eoi_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sys_valid, sys_write, sys_done, ack_valid, deact_valid, drop_valid;
   logic system_error_interrupt, bp_nonsecure_g1_uses_g0, bp_secure_g1_uses_g0;
   sysenc_s sys_enc;
   logic [63:0] sys_wdata, sys_rdata;
   ctx_s sys_ctx;
   resp_s sys_resp;
   logic [ID_W-1:0] ack_id, deact_id, drop_id;
   logic [PRIO_W-1:0] ack_prio, running_prio;
   logic [1:0] lower_level_control_ns, lower_level_control_s;
   logic [ACT_DEPTH-1:0] active_mask;
   int err_count = 0;
   int checked = 0;
   localparam sysenc_s CTL = '{OP0_SYS, OP1_TOP, CRN_IC, CRM_CTL, OP2_CTL};
   localparam sysenc_s DIR = '{OP0_SYS, OP1_LOW, CRN_IC, CRM_DEACT, OP2_DEACT};
   localparam sysenc_s EOI = '{OP0_SYS, OP1_LOW, CRN_IC, CRM_EOI0, OP2_EOI0};
   logic [4:0] pat [2] = '{5'h16, 5'h09};
   logic [7:0] trp [4] = '{8'h38, 8'h34, 8'h32, 8'h31};
   logic [1:0] sel [3] = '{2'h2, 2'h0, 2'h3};

   always #50 clk = ~clk;

   eoi_deactivation_control eoi_deactivation_control_inst (
      .clk, .rst_n, .sys_valid, .sys_write, .sys_enc, .sys_wdata, .sys_ctx, .sys_rdata,
      .sys_resp, .sys_done, .lower_level_control_ns, .lower_level_control_s, .ack_valid,
      .ack_id, .ack_prio, .deact_valid, .deact_id, .drop_valid, .drop_id,
      .system_error_interrupt, .bp_nonsecure_g1_uses_g0, .bp_secure_g1_uses_g0,
      .running_prio, .active_mask);
   core_model core_model_inst (
      .clk, .sys_valid, .sys_write, .sys_enc, .sys_wdata, .sys_ctx, .sys_rdata, .sys_resp,
      .sys_done, .ack_valid, .ack_id, .ack_prio);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic ctx(input level_e lv, input logic [7:0] f);
      core_model_inst.sys_ctx = {lv, f};
   endtask : ctx
   task automatic op(input logic wr, input sysenc_s e, input logic [63:0] d, input result_e r);
      core_model_inst.access(wr, e, d);
      chk(core_model_inst.done_got, 1'b1);
      chk(core_model_inst.resp_got.result, r);
   endtask : op
   task automatic fx(input logic [2:0] exp);
      chk({drop_valid, deact_valid, system_error_interrupt}, exp);
   endtask : fx
   task automatic tick;
      @(posedge clk);
      #1;
   endtask : tick
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      close_out();
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      #1;
      rst_n = 1'b1;
      chk({sys_done, drop_valid, deact_valid, running_prio, active_mask}, {3'h0, IDLE_PRIO, 8'h0});
      chk(sys_resp.result, RES_NONE);
      $display("Test reset finished");
      foreach (pat[i]) begin
         op(1'b1, CTL, {59'h0, pat[i]}, RES_OK);
         op(1'b0, CTL, 64'h0, RES_OK);
         chk(core_model_inst.rdata_got, {59'h0, pat[i]});
         chk({lower_level_control_ns, lower_level_control_s}, {pat[i][4], pat[i][1], pat[i][3], pat[i][0]});
         chk({bp_nonsecure_g1_uses_g0, bp_secure_g1_uses_g0}, pat[i][1:0]);
      end
      $display("Test control fields finished");
      for (int lv = 0; lv < 3; lv++) begin
         ctx(level_e'(4'h1 << lv), 8'h60);
         op(lv[0], CTL, 64'h0, RES_UNDEF);
      end
      ctx(EL3, 8'h20);
      op(1'b1, CTL, 64'h0, RES_TRAP);
      chk(core_model_inst.resp_got, {RES_TRAP, EL3, TRAP_CLASS});
      op(1'b0, DIR, 64'h0, RES_TRAP);
      ctx(EL1, 8'h40);
      op(1'b1, DIR, 64'h5, RES_TRAP);
      chk(core_model_inst.resp_got, {RES_TRAP, EL1, TRAP_CLASS});
      foreach (trp[i]) begin
         ctx(EL1, trp[i]);
         op(1'b1, DIR, 64'h5, i < 2 ? RES_TRAP : RES_VIRT);
         fx(3'h0);
      end
      ctx(EL0, 8'h60);
      op(1'b1, DIR, 64'h5, RES_UNDEF);
      fx(3'h0);
      ctx(EL3, 8'h40);
      op(1'b0, DIR, 64'h0, RES_UNDEF);
      op(1'b1, '{OP0_SYS, OP1_LOW, CRN_IC, 4'h9, OP2_EOI0}, 64'h0, RES_NONE);
      $display("Test refusals finished");
      op(1'b1, CTL, 64'h0, RES_OK);
      core_model_inst.ack(24'h5, 8'h40);
      chk({running_prio, active_mask != 0}, {8'h40, 1'b1});
      op(1'b1, EOI, 64'hffff_ffff_ff00_0005, RES_OK);
      fx(3'h6);
      chk({drop_id, deact_id}, {24'h5, 24'h5});
      tick();
      chk({running_prio, active_mask}, {IDLE_PRIO, 8'h0});
      op(1'b1, DIR, 64'h5, RES_OK);
      fx(3'h1);
      op(1'b1, EOI, 64'h3fd, RES_OK);
      fx(3'h0);
      $display("Test mode zero finished");
      op(1'b1, CTL, 64'h4, RES_OK);
      core_model_inst.ack(24'h7, 8'h20);
      op(1'b1, EOI, 64'h7, RES_OK);
      fx(3'h4);
      tick();
      chk({running_prio, active_mask != 0}, {IDLE_PRIO, 1'b1});
      op(1'b1, DIR, 64'h7, RES_OK);
      fx(3'h2);
      chk(deact_id, 24'h7);
      tick();
      chk(active_mask, 8'h0);
      core_model_inst.ack(24'h9, 8'h30);
      op(1'b1, DIR, 64'h9, RES_OK);
      fx(3'h2);
      tick();
      chk(running_prio, 8'h30);
      op(1'b1, EOI, 64'h9, RES_OK);
      fx(3'h4);
      $display("Test mode one finished");
      op(1'b1, CTL, 64'h10, RES_OK);
      foreach (sel[i]) begin
         ctx(sel[i][0] ? EL3 : EL2, {sel[i][1], 7'h40});
         op(1'b1, EOI, 64'h2a, RES_OK);
         fx({1'b1, !sel[i][1] || sel[i][0], 1'b0});
      end
      $display("Test mode selection finished");
      close_out();
   end
endmodule : testbench
